// *** src/cfg_word_pkg.sv ***
// Package for the configuration word decoder.
// Holds register offsets, field positions, reset values and codes.
// Assumes an APB slave with 32-bit data, one word per register.
package cfg_word_pkg;
	localparam logic [11:0] cfg_offset       = 12'h000; // Live configuration word
	localparam logic [11:0] load_offset      = 12'h004; // Write to load a new word
	localparam logic [11:0] status_offset    = 12'h008; // Decoded state and errors
	localparam int          cfg_width        = 24;
	localparam logic [23:0] cfg_reset_value  = 24'hff7fff; // Erased word, bit 15 as zero
	localparam logic [7:0]  upper_ones       = 8'hff;
	localparam int          upper_lsb        = 16;
	localparam int          rsvd_top_bit     = 15;
	localparam int          scan_port_bit    = 14;
	localparam int          code_protect_bit = 13;
	localparam int          write_protect_bit = 12;
	localparam int          debug_bit        = 11;
	localparam int          rsvd_one_bit     = 10;
	localparam int          pin_pair_lsb     = 8;
	localparam int          wdt_enable_bit   = 7;
	localparam int          window_dis_bit   = 6;
	localparam int          ref_sel_bit      = 5;
	localparam int          prescale_bit     = 4;
	localparam int          postscale_lsb    = 0;
	localparam logic [1:0]  pair_one_code    = 2'h3;
	localparam logic [1:0]  pair_two_code    = 2'h2;
	localparam logic [1:0]  pair_three_code  = 2'h1;
	localparam logic [2:0]  pair_none        = 3'h0;
	typedef enum logic [1:0] {
		st_idle,
		st_decode
	} load_state_e;
endpackage : cfg_word_pkg

// *** src/config_word_decode.sv ***
// Configuration word decoder with APB access to the stored word.
// Assumes a 10 MHz pclk and software loading the word before use.
// Decoded outputs change only after a two-step load sequence.

// Overview of operation
// - Bits 23 to 16 of the configuration word always read back as ones.
// - The scan test port is enabled exactly when bit 14 is one.
// - Whole program memory is code protected when bit 13 is zero.
// - Program memory writes are blocked when bit 12 is zero.
// - Debug mode is entered after reset when bit 11 is zero, else operational mode.
// - Field 9-8 picks the emulator pin pair, 11 one, 10 two, 01 three, 00 reserved.
// - The watchdog runs exactly when bit 7 is one.
// - Windowed watchdog when bit 6 is zero, which needs bit 7 at one.
// - Converter reference is on default pins when bit 5 is one, alternate when zero.
module config_word_decode (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             scan_port_enable,
	output logic             code_protect_active,
	output logic             write_block_active,
	output logic             debug_mode,
	output logic      [2:0]  emulator_pair_onehot,
	output logic             watchdog_run,
	output logic             watchdog_windowed,
	output logic             reference_default_pins,
	output logic             watchdog_prescale_sel,
	output logic      [3:0]  watchdog_postscale_field
);
	////////////////////////////////////////////////////////////////////////////////
	// Stored word and load sequencing
	logic [23:0]                cfg_reg, cfg_next;
	logic [23:0]                pend_reg, pend_next;
	cfg_word_pkg::load_state_e  state_reg, state_next;
	logic                       err_reg, err_next;
	logic [2:0]                 pair_onehot;
	logic                       sel_reserved;
	logic                       access, wr_cfg, wr_load;
	logic [23:0]                cfg_read;

	assign access  = psel && penable;
	assign wr_cfg  = access && pwrite && (paddr == cfg_word_pkg::cfg_offset);
	assign wr_load = access && pwrite && (paddr == cfg_word_pkg::load_offset);

	// Upper byte forced to ones on read; bit 15 read as stored, not trusted
	assign cfg_read = {cfg_word_pkg::upper_ones, cfg_reg[15:0]};

	// Pending word is staged, then committed on a load write
	always_comb begin
		pend_next  = pend_reg;
		cfg_next   = cfg_reg;
		state_next = state_reg;
		err_next   = err_reg;
		if (wr_cfg) begin
			// Byte strobes for the low two lanes; the upper lane is never stored
			if (pstrb[0])
				pend_next[7:0] = pwdata[7:0];
			if (pstrb[1])
				pend_next[15:8] = pwdata[15:8];
		end
		case (state_reg)
			cfg_word_pkg::st_idle: begin
				if (wr_load)
					state_next = cfg_word_pkg::st_decode;
			end
			cfg_word_pkg::st_decode: begin
				cfg_next   = {cfg_word_pkg::upper_ones, pend_reg[15:0]};
				// Sticky flag for words that break the programmer's duties
				err_next   = err_reg
					|| pend_reg[cfg_word_pkg::rsvd_top_bit]
					|| !pend_reg[cfg_word_pkg::rsvd_one_bit]
					|| (pend_reg[9:8] == 2'h0)
					|| (!pend_reg[cfg_word_pkg::window_dis_bit]
						&& !pend_reg[cfg_word_pkg::wdt_enable_bit]);
				state_next = cfg_word_pkg::st_idle;
			end
			default: state_next = cfg_word_pkg::st_idle;
		endcase
		// A status write of bit 0 clears the error unless a load decodes in the same cycle
		if (access && pwrite && paddr == cfg_word_pkg::status_offset && pwdata[0]
			&& state_reg != cfg_word_pkg::st_decode)
			err_next = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg   <= cfg_word_pkg::cfg_reset_value;
			pend_reg  <= cfg_word_pkg::cfg_reset_value;
			state_reg <= cfg_word_pkg::st_idle;
			err_reg   <= 1'b0;
		end else begin
			cfg_reg   <= cfg_next;
			pend_reg  <= pend_next;
			state_reg <= state_next;
			err_reg   <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin pair decoding
	pin_pair_decode u_pair (
		.sel          (cfg_reg[9:8]),
		.pair_onehot  (pair_onehot),
		.sel_reserved (sel_reserved)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB read data and answer; zero wait states
	logic [31:0] prdata_next;
	logic        pslverr_next;
	logic        pready_next;

	always_comb begin
		prdata_next  = 32'h0000_0000;
		pslverr_next = 1'b0;
		pready_next  = 1'b0;
		if (psel && !penable) begin
			pready_next = 1'b1;
			case (paddr)
				cfg_word_pkg::cfg_offset:    prdata_next = {8'h00, cfg_read};
				cfg_word_pkg::load_offset:   prdata_next = 32'h0000_0000;
				cfg_word_pkg::status_offset: prdata_next =
					{28'h0, sel_reserved, state_reg == cfg_word_pkg::st_decode, 1'b0, err_reg};
				default:                     pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pready  <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoded outputs, registered so they come straight from flip-flops
	logic       scan_next, code_protect_next, write_block_next, debug_next;
	logic [2:0] pair_next;
	logic       run_next, windowed_next, ref_pins_next, prescale_next;
	logic [3:0] postscale_next;

	// Next decoded values follow the live word; they settle one edge after it
	always_comb begin
		scan_next         = cfg_reg[cfg_word_pkg::scan_port_bit];
		code_protect_next = !cfg_reg[cfg_word_pkg::code_protect_bit];
		write_block_next  = !cfg_reg[cfg_word_pkg::write_protect_bit];
		debug_next        = !cfg_reg[cfg_word_pkg::debug_bit];
		pair_next         = pair_onehot;
		run_next          = cfg_reg[cfg_word_pkg::wdt_enable_bit];
		// Windowed only with the watchdog running; a bad word gives standard
		windowed_next     = !cfg_reg[cfg_word_pkg::window_dis_bit]
			&& cfg_reg[cfg_word_pkg::wdt_enable_bit];
		ref_pins_next     = cfg_reg[cfg_word_pkg::ref_sel_bit];
		prescale_next     = cfg_reg[cfg_word_pkg::prescale_bit];
		postscale_next    = cfg_reg[3:0];
	end

	// Reset values match the decode of the erased word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_port_enable         <= 1'b1;
			code_protect_active      <= 1'b0;
			write_block_active       <= 1'b0;
			debug_mode               <= 1'b0;
			emulator_pair_onehot     <= 3'h1;
			watchdog_run             <= 1'b1;
			watchdog_windowed        <= 1'b0;
			reference_default_pins   <= 1'b1;
			watchdog_prescale_sel    <= 1'b1;
			watchdog_postscale_field <= 4'hf;
		end else begin
			scan_port_enable         <= scan_next;
			code_protect_active      <= code_protect_next;
			write_block_active       <= write_block_next;
			debug_mode               <= debug_next;
			emulator_pair_onehot     <= pair_next;
			watchdog_run             <= run_next;
			watchdog_windowed        <= windowed_next;
			reference_default_pins   <= ref_pins_next;
			watchdog_prescale_sel    <= prescale_next;
			watchdog_postscale_field <= postscale_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_load_done;
		state_reg == cfg_word_pkg::st_decode ##1 state_reg == cfg_word_pkg::st_idle;
	endsequence

	a_upper_ones_read: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_reg[23:16] == 8'hff) else $error("Upper byte not all ones");
	a_scan_follows_bit: assert property (@(posedge pclk) disable iff (!presetn)
		##1 scan_port_enable == $past(cfg_reg[14])) else $error("Scan enable wrong");
	a_code_protect_low: assert property (@(posedge pclk) disable iff (!presetn)
		##1 code_protect_active != $past(cfg_reg[13])) else $error("Code protect wrong");
	a_write_block_low: assert property (@(posedge pclk) disable iff (!presetn)
		##1 write_block_active != $past(cfg_reg[12])) else $error("Write block wrong");
	a_debug_entry_sel: assert property (@(posedge pclk) disable iff (!presetn)
		##1 debug_mode != $past(cfg_reg[11])) else $error("Debug mode wrong");
	a_pair_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
		##1 emulator_pair_onehot == {$past(cfg_reg[9:8]) == 2'h1, $past(cfg_reg[9:8]) == 2'h2,
			$past(cfg_reg[9:8]) == 2'h3}) else $error("Pair wrong");
	a_wdt_run_bit: assert property (@(posedge pclk) disable iff (!presetn)
		##1 watchdog_run == $past(cfg_reg[7])) else $error("Watchdog run wrong");
	a_window_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
		##1 watchdog_windowed == (!$past(cfg_reg[6]) && $past(cfg_reg[7])))
		else $error("Window mode wrong");
	a_ref_pins_bit: assert property (@(posedge pclk) disable iff (!presetn)
		##1 reference_default_pins == $past(cfg_reg[5])) else $error("Reference pins wrong");
	a_postscale_pass: assert property (@(posedge pclk) disable iff (!presetn)
		s_load_done |=> watchdog_postscale_field == $past(cfg_reg[3:0]))
		else $error("Postscale not passed");
endmodule // config_word_decode

// *** src/pin_pair_decode.sv ***
// Decoder for the emulator pin pair field.
// Assumes a stable two-bit field; purely combinational.
module pin_pair_decode (
	input  wire logic [1:0] sel,
	output logic      [2:0] pair_onehot,
	output logic            sel_reserved
);
	////////////////////////////////////////////////////////////////////////////////
	// One-hot pair choice; the reserved code routes to no pair
	always_comb begin
		pair_onehot  = cfg_word_pkg::pair_none;
		sel_reserved = 1'b0;
		case (sel)
			cfg_word_pkg::pair_one_code:   pair_onehot = 3'h1;
			cfg_word_pkg::pair_two_code:   pair_onehot = 3'h2;
			cfg_word_pkg::pair_three_code: pair_onehot = 3'h4;
			default:                       sel_reserved = 1'b1;
		endcase
	end
endmodule // pin_pair_decode

// *** test/config_word_decode_bench.sv ***
// Self-checking bench for the configuration word decoder.
// Assumes the APB slave answers with pready and loads the word one edge after a load write, with decoded outputs one edge later.
module config_word_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed { logic [31:0] data; logic [31:0] mask; logic err; } bus_note_s;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [3:0]  pstrb, post;
	logic        pready, pslverr, scan, cp, wb, dbg, run, win, refp, pre;
	logic [2:0]  pair;
	logic [14:0] pend;
	logic [15:0] w;
	int          num_errors = 0, checks = 0, cyc = 0, due = 4;
	bus_note_s   bus_q[$], b;
	logic [14:0] out_q[$];
	config_word_decode u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scan_port_enable(scan), .code_protect_active(cp),
		.write_block_active(wb), .debug_mode(dbg), .emulator_pair_onehot(pair),
		.watchdog_run(run), .watchdog_windowed(win), .reference_default_pins(refp),
		.watchdog_prescale_sel(pre), .watchdog_postscale_field(post));
	////////////////////////////////////////////////////////////////////////////////
	// Expected decode of a low word, worked out independently of the design
	function automatic logic [14:0] exp_out(input logic [15:0] v);
		logic [2:0] oh;
		case (v[9:8])
			2'h3: oh = 3'h1;
			2'h2: oh = 3'h2;
			2'h1: oh = 3'h4;
			default: oh = 3'h0;
		endcase
		return {v[14], !v[13], !v[12], !v[11], oh, v[7], !v[6] && v[7], v[5], v[4], v[3:0]};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One APB transfer; the note goes on the queue before the request starts
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic [31:0] em, input logic ee);
		bus_q.push_back('{ed, em, ee});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait as long as the slave takes; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the limit is far above the expected run length
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#400000;
		num_errors++;
		final_report();
	end
	// Watcher: takes the oldest note whenever a transfer completes, and the oldest expected decode on a load write
	always @(posedge pclk) begin
		cyc = cyc + 1;
		// After reset the outputs must show the decode of the erased word, checked at cycle 4
		if (!presetn)
			pend = exp_out(cfg_word_pkg::cfg_reset_value[15:0]);
		if (presetn && psel && penable && pready === 1'b1 && bus_q.size() > 0) begin
			b = bus_q.pop_front();
			compare("prdata", prdata & b.mask, b.data & b.mask);
			compare("pslverr", {31'h0, pslverr}, {31'h0, b.err});
			if (pwrite && !b.err && paddr == cfg_word_pkg::load_offset && out_q.size() > 0) begin
				pend = out_q.pop_front();
				due = cyc + 4;
			end
		end
		if (cyc == due)
			compare("outputs", {17'h0, scan, cp, wb, dbg, pair, run, win, refp, pre, post},
				{17'h0, pend});
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, random loads with readback, unmapped accesses
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		pstrb   = 4'hf;
		seed    = 32'he7a1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, cfg_word_pkg::cfg_offset, 32'h0, 32'h00ff7fff, 32'h00ffffff, 1'b0);
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(lfsr(seed));
			w = seed[15:0];
			w[15] = 1'b0;
			w[10] = 1'b1;
			if (w[9:8] == 2'h0) w[9:8] = 2'h3;
			if (!w[6]) w[7] = 1'b1;
			if (i == 0) w[5] = 1'b1;
			out_q.push_back(exp_out(w));
			// Upper bytes carry noise that the decoder must ignore
			apb(1'b1, cfg_word_pkg::cfg_offset, {seed[31:16], w}, 32'h0, 32'h0, 1'b0);
			apb(1'b1, cfg_word_pkg::load_offset, seed, 32'h0, 32'h0, 1'b0);
			repeat (5) @(posedge pclk);
			apb(1'b0, cfg_word_pkg::cfg_offset, 32'h0, {8'h0, 8'hff, w}, 32'h00ffffff, 1'b0);
		end
		// Unmapped place: refused, read zero, write without effect
		apb(1'b1, 12'h00c, 32'hffffffff, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b0, cfg_word_pkg::cfg_offset, 32'h0, {8'h0, 8'hff, w}, 32'h00ffffff, 1'b0);
		// Broken word: bit 15 set and pin pair field 00 raise the sticky error
		w = 16'hfcff;
		out_q.push_back(exp_out(w));
		apb(1'b1, cfg_word_pkg::cfg_offset, {16'h0, w}, 32'h0, 32'h0, 1'b0);
		apb(1'b1, cfg_word_pkg::load_offset, 32'h0, 32'h0, 32'h0, 1'b0);
		repeat (5) @(posedge pclk);
		apb(1'b0, cfg_word_pkg::status_offset, 32'h0, 32'h9, 32'hf, 1'b0);
		// Clearing drops the error; the reserved field stays flagged
		apb(1'b1, cfg_word_pkg::status_offset, 32'h1, 32'h0, 32'h0, 1'b0);
		apb(1'b0, cfg_word_pkg::status_offset, 32'h0, 32'h8, 32'hf, 1'b0);
		repeat (4) @(posedge pclk);
		final_report();
	end
endmodule // config_word_decode_bench
